// [bench/aopc_host.sv]
// host model clocking results out in external clock mode
`timescale 1ns/1ns
module aopc_host (
	input wire logic inv_i,
	input wire logic sdo_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic [15:0] word_o,
	output logic done_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		word_o = 16'h0000;
		done_o = 1'b0;
	end

	// clock runs only inside a frame, 12 ns period
	task automatic frame();
		sclk_o = inv_i;
		cs_n_o = 1'b0;
		done_o = 1'b0;
		for (int i = 0; i < 19; i++) begin
			#6;
			sclk_o = ~inv_i;
			#6;
			sclk_o = inv_i;
			if (i >= 2 && i < 18) word_o = {word_o[14:0], sdo_i};
		end
		#6;
		cs_n_o = 1'b1;
		done_o = 1'b1;
	endtask
endmodule // aopc_host

// [bench/aopc_top_asserts.sv]
// pin-level assertions for the output port block
`timescale 1ns/1ns
`include "aopc_params.svh"
module aopc_top_asserts
	import aopc_pkg::*;
#(
	parameter int FAST_IDLE_CYC = `AOPC_FAST_IDLE_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic result_encoding_select_i,
	input wire logic fast_mode_select_i,
	input wire logic low_power_select_i,
	input wire logic port_type_select_i,
	input wire logic [7:4] data_i,
	input wire logic [15:0] result_i,
	input wire logic result_valid_i,
	input wire logic [15:0] data_o,
	input wire logic [7:4] data_oe_n_o,
	input wire logic serial_result_out_o,
	input wire logic sclk_o,
	input wire logic sclk_oe_n_o,
	input wire logic frame_sync_o,
	input wire aopc_mode_t conv_mode_o,
	input wire logic accuracy_risk_o
);
	aopc_mode_t mode_exp;
	assign mode_exp = !fast_mode_select_i ? (low_power_select_i ? AOPC_MODE_LOW_POWER :
		AOPC_MODE_NORMAL) : (low_power_select_i ? AOPC_MODE_UNSUPPORTED : AOPC_MODE_FAST);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	port_oe_a: assert property (
		$stable(port_type_select_i) [*6] |-> data_oe_n_o == {4{port_type_select_i}})
		else $error("pin direction wrong");
	clk_src_a: assert property (
		$stable({port_type_select_i, data_i[4]}) [*6]
		|-> sclk_oe_n_o == !(port_type_select_i && !data_i[4]))
		else $error("clock direction wrong");
	mode_decode_a: assert property (
		$stable({fast_mode_select_i, low_power_select_i}) [*6] |-> conv_mode_o == mode_exp)
		else $error("mode wrong");
	enc_binary_a: assert property (
		(!port_type_select_i && result_encoding_select_i) [*6] ##0 result_valid_i
		|-> ##2 data_o == $past(result_i, 2))
		else $error("binary word wrong");
	enc_twos_a: assert property (
		(!port_type_select_i && !result_encoding_select_i) [*6] ##0 result_valid_i
		|-> ##2 data_o == ($past(result_i, 2) ^ 16'h8000))
		else $error("twos word wrong");
	msb_first_a: assert property (
		(port_type_select_i && data_i == 4'h0 && result_encoding_select_i) [*6]
		##0 (result_valid_i && !frame_sync_o)
		|-> ##2 (frame_sync_o && serial_result_out_o == $past(result_i[15], 2)))
		else $error("frame start wrong");
	sclk_shape_a: assert property (
		$rose(frame_sync_o) && data_i[6:5] == 2'b00 && !sclk_oe_n_o
		|-> !sclk_o ##1 sclk_o [*4] ##1 !sclk_o [*2] ##1 sclk_o)
		else $error("clock shape wrong");
	frame_len_a: assert property (
		$rose(frame_sync_o) && !data_i[5] && !sclk_oe_n_o
		|-> ##96 frame_sync_o ##1 !frame_sync_o)
		else $error("sync length wrong");
	risk_off_a: assert property (
		(conv_mode_o != AOPC_MODE_FAST) [*3] |-> !accuracy_risk_o)
		else $error("risk flag wrong");
endmodule // aopc_top_asserts

bind aopc_top aopc_top_asserts #(.FAST_IDLE_CYC(FAST_IDLE_CYC)) u_chk (.*);

// [bench/tb.sv]
// self-checking testbench for the output port block
`timescale 1ns/1ns
module tb;
	import aopc_pkg::*;
	localparam int IDLE = 50;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic result_encoding_select_i = 1'b1;
	logic fast_mode_select_i = 1'b0;
	logic low_power_select_i = 1'b0;
	logic port_type_select_i = 1'b0;
	logic result_valid_i = 1'b0;
	logic conv_start_i = 1'b0;
	logic [7:4] data_i = 4'h0;
	logic [15:0] result_i = 16'h0000;
	logic sclk_ext_i, cs_n_i, serial_result_out_o, sclk_o, sclk_oe_n_o;
	logic frame_sync_o, accuracy_risk_o, hdone;
	logic [7:4] data_oe_n_o;
	logic [15:0] data_o, hword, mw, lv;
	logic [15:0] q[$];
	logic [1:0] pv = 2'b00;
	aopc_mode_t conv_mode_o;
	aopc_mode_t mt[4] = '{AOPC_MODE_NORMAL, AOPC_MODE_FAST, AOPC_MODE_LOW_POWER,
		AOPC_MODE_UNSUPPORTED};
	int error_cnt = 0;
	int compares = 0;
	int mb = 0;

	aopc_top #(.FAST_IDLE_CYC(IDLE)) DUT (.*);
	aopc_host host (.inv_i(data_i[6]), .sdo_i(serial_result_out_o), .sclk_o(sclk_ext_i),
		.cs_n_o(cs_n_i), .word_o(hword), .done_o(hdone));

	always #4 core_clk_i = ~core_clk_i;

	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic take(string n, logic [15:0] s);
		chk(n, s, (q.size() > 0) ? q.pop_front() : 16'hXXXX);
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic send(logic [15:0] v);
		result_i = v;
		lv = v;
		q.push_back(v ^ {~result_encoding_select_i, 15'h0000});
		result_valid_i = 1'b1;
		cyc(1);
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	always @(negedge core_clk_i) begin
		if (pv[1]) take("parallel", data_o);
		pv = {pv[0], result_valid_i && !port_type_select_i};
	end

	// gather master bits on the sampling edge of the internal clock
	always @(sclk_o) begin
		if (sclk_oe_n_o === 1'b0 && sclk_o === data_i[6] && frame_sync_o === ~data_i[5]) begin
			mw = {mw[14:0], serial_result_out_o};
			mb++;
			if (mb == 16) begin
				take("master", mw);
				mb = 0;
			end
		end
	end

	always @(posedge hdone) take("slave", hword);

	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end

	initial begin
		void'($urandom(32'hEF46DF8D));
		cyc(5);
		rst_i = 1'b0;
		cyc(4);
		for (int i = 0; i < 4; i++) begin
			result_encoding_select_i = i[0];
			data_i = 4'($urandom);
			cyc(6);
			send(16'($urandom));
			send(16'($urandom));
			result_valid_i = 1'b0;
			cyc(3);
			chk("oe", {12'h000, data_oe_n_o}, 16'h0000);
		end
		$display("test parallel done");
		for (int i = 0; i < 4; i++) begin
			fast_mode_select_i = i[0];
			low_power_select_i = i[1];
			cyc(5);
			chk("mode", {14'h0, conv_mode_o}, {14'h0, mt[i]});
		end
		low_power_select_i = 1'b0;
		cyc(IDLE + 10);
		chk("risk", {15'h0, accuracy_risk_o}, 16'h0001);
		send(16'($urandom));
		result_valid_i = 1'b0;
		cyc(3);
		chk("risk", {15'h0, accuracy_risk_o}, 16'h0000);
		fast_mode_select_i = 1'b0;
		cyc(IDLE + 10);
		chk("risk", {15'h0, accuracy_risk_o}, 16'h0000);
		$display("test modes done");
		port_type_select_i = 1'b1;
		for (int i = 0; i < 5; i++) begin
			result_encoding_select_i = !i[0];
			data_i = (i == 4) ? 4'h8 : {1'b0, i[0], i[1], 1'b0};
			cyc(6);
			mb = 0;
			chk("sclk_oe", {15'h0, sclk_oe_n_o}, 16'h0000);
			send(16'($urandom));
			result_valid_i = 1'b0;
			if (i == 4) begin
				cyc(3);
				conv_start_i = 1'b1;
				cyc(1);
				conv_start_i = 1'b0;
			end
			cyc(110);
			chk("low bits", data_o, {12'h000, lv[3:0]});
		end
		$display("test master done");
		for (int i = 0; i < 2; i++) begin
			data_i = {1'($urandom), i[0], 1'b0, 1'b1};
			cyc(6);
			chk("sclk_oe", {15'h0, sclk_oe_n_o}, 16'h0001);
			send(16'($urandom));
			result_valid_i = 1'b0;
			cyc(4);
			host.frame();
			cyc(4);
		end
		$display("test slave done");
		chk("left over", 16'(q.size()), 16'h0000);
		finish_test();
	end
endmodule // tb

// [design/aopc_params.svh]
// timing counts, pin positions and reset values of the output port configuration block
`ifndef AOPC_PARAMS_SVH
`define AOPC_PARAMS_SVH

// ----------------------------------------------------------------
// clocks and timing
// ----------------------------------------------------------------
`define AOPC_CORE_PERIOD_PS 8000
`define AOPC_CORE_MHZ 125
`define AOPC_FAST_IDLE_MAX_US 1000
`define AOPC_FAST_IDLE_CYC (`AOPC_FAST_IDLE_MAX_US * `AOPC_CORE_MHZ)
`define AOPC_SCLK_HIGH_MIN_PS 30000
`define AOPC_SCLK_LOW_MIN_PS 9500
`define AOPC_SCLK_HIGH_CYC ((`AOPC_SCLK_HIGH_MIN_PS + `AOPC_CORE_PERIOD_PS - 1) / `AOPC_CORE_PERIOD_PS)
`define AOPC_SCLK_LOW_CYC ((`AOPC_SCLK_LOW_MIN_PS + `AOPC_CORE_PERIOD_PS - 1) / `AOPC_CORE_PERIOD_PS)
`define AOPC_SCLK_MID_CYC (`AOPC_SCLK_HIGH_CYC / 2)

// ----------------------------------------------------------------
// word and pin layout
// ----------------------------------------------------------------
`define AOPC_WORD_W 16
`define AOPC_WORD_BITS 5'h10
`define AOPC_PIN_CLK_SRC 0
`define AOPC_PIN_SYNC_POL 1
`define AOPC_PIN_CLK_INV 2
`define AOPC_PIN_READ_MODE 3
`define AOPC_WORD_RST 16'h0000
`define AOPC_IDLE_W 17

`endif

// [design/aopc_pkg.sv]
// types shared by the output port configuration block
package aopc_pkg;
	typedef enum logic [1:0] {
		AOPC_MODE_NORMAL,
		AOPC_MODE_FAST,
		AOPC_MODE_LOW_POWER,
		AOPC_MODE_UNSUPPORTED
	} aopc_mode_t;

	typedef enum logic [2:0] {
		AOPC_MS_IDLE,
		AOPC_MS_SYNC,
		AOPC_MS_HIGH,
		AOPC_MS_LOW,
		AOPC_MS_END
	} aopc_mst_state_t;
endpackage

// [design/aopc_ser_if.sv]
// word handoff and pin signals between the core logic and the external clock shifter
`timescale 1ns/1ns
interface aopc_ser_if;
	logic [15:0] hold_word;
	logic req_tgl;
	logic ack_tgl;
	logic cs_n;
	logic chain_in;
	logic sdo;

	modport core (
		output hold_word,
		output req_tgl,
		input ack_tgl,
		output cs_n,
		output chain_in,
		input sdo
	);

	modport link (
		input hold_word,
		input req_tgl,
		output ack_tgl,
		input cs_n,
		input chain_in,
		output sdo
	);
endinterface

// [design/aopc_ser_link.sv]
// shifter clocked by the host-supplied serial clock
`timescale 1ns/1ns
`include "aopc_params.svh"
module aopc_ser_link
	import aopc_pkg::*;
(
	input wire logic link_clk_i,
	input wire logic rst_i,
	aopc_ser_if.link ser
);
	logic req_s1_r;
	logic req_s2_r;
	logic ack_r;
	logic sdo_r;
	logic [15:0] shreg_r;
	logic [4:0] cnt_r;

	assign ser.ack_tgl = ack_r;
	assign ser.sdo = sdo_r;

	// ----------------------------------------------------------------
	// request toggle crossing
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
		end else begin
			req_s1_r <= ser.req_tgl;
			req_s2_r <= req_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// shift out msb first, chain input fills from the bottom
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg_r <= `AOPC_WORD_RST;
			cnt_r <= 5'h00;
			ack_r <= 1'b0;
			sdo_r <= 1'b0;
		end else if (ser.cs_n) begin
			cnt_r <= 5'h00;
		end else if (cnt_r == 5'h00) begin
			if (req_s2_r != ack_r) begin
				sdo_r <= ser.hold_word[15]; // R10
				shreg_r <= {ser.hold_word[14:0], ser.chain_in};
				cnt_r <= 5'h01;
				ack_r <= ~ack_r;
			end
		end else if (cnt_r == `AOPC_WORD_BITS) begin
			cnt_r <= 5'h00;
		end else begin
			sdo_r <= shreg_r[15]; // R11
			shreg_r <= {shreg_r[14:0], ser.chain_in};
			cnt_r <= cnt_r + 5'h01;
		end
	end
endmodule // aopc_ser_link

// [design/aopc_top.sv]
// output port configuration: encoding, mode decode, parallel port and serial port
//
// Contract
// R1: encoding high straight binary, low inverts msb
// R2: fast mode when fast high, low power low
// R3: fast select low keeps accuracy at any rate
// R4: low power high, fast low: reduced power
// R5: port select low parallel, high serial
// R6: data bits zero to three always outputs
// R7: bit four: parallel output, serial clock source
// R8: bit five: parallel output, serial sync polarity
// R9: bit six: parallel output, serial clock invert
// R10: serial result shifted out msb first
// R11: external clock: update rising edge, inversion swaps
// R12: internal clock: read mode picks during/after conversion
// R13: both selects low normal, both high unsupported
`timescale 1ns/1ns
`include "aopc_params.svh"
module aopc_top
	import aopc_pkg::*;
#(
	parameter int FAST_IDLE_CYC = `AOPC_FAST_IDLE_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic sclk_ext_i,
	input wire logic cs_n_i,
	input wire logic result_encoding_select_i,
	input wire logic fast_mode_select_i,
	input wire logic low_power_select_i,
	input wire logic port_type_select_i,
	input wire logic [7:4] data_i,
	input wire logic [15:0] result_i,
	input wire logic result_valid_i,
	input wire logic conv_start_i,
	output logic [15:0] data_o,
	output logic [7:4] data_oe_n_o,
	output logic serial_result_out_o,
	output logic sclk_o,
	output logic sclk_oe_n_o,
	output logic frame_sync_o,
	output aopc_mode_t conv_mode_o,
	output logic accuracy_risk_o
);
	localparam logic [2:0] HIGH_LAST = 3'(`AOPC_SCLK_HIGH_CYC - 1);
	localparam logic [2:0] LOW_LAST = 3'(`AOPC_SCLK_LOW_CYC - 1);
	localparam logic [2:0] MID_PH = 3'(`AOPC_SCLK_MID_CYC);
	localparam logic [16:0] IDLE_LIMIT = 17'(FAST_IDLE_CYC);

	aopc_ser_if ser ();

	logic [7:0] pin_s1_r;
	logic [7:0] pin_s2_r;
	logic enc_sel;
	logic fast_sel;
	logic lp_sel;
	logic ser_sel;
	logic ext_clk;
	logic sync_pol;
	logic clk_inv;
	logic read_mode;
	logic [15:0] coded;
	logic [15:0] word_r;
	logic [15:0] data_r;
	logic [7:4] oe_n_r;
	aopc_mode_t mode_r;
	logic [16:0] idle_cnt_r;
	logic risk_r;
	logic [15:0] hold_r;
	logic req_r;
	logic ack_s1_r;
	logic ack_s2_r;
	aopc_mst_state_t ms_r;
	logic [2:0] ph_r;
	logic [4:0] bit_r;
	logic [15:0] mshift_r;
	logic msdo_r;
	logic sclk_r;
	logic sclk_oe_n_r;
	logic sync_r;
	logic mst_start;
	logic link_clk;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
		end else begin
			pin_s1_r <= {data_i, port_type_select_i, low_power_select_i,
				fast_mode_select_i, result_encoding_select_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign enc_sel = pin_s2_r[0];
	assign fast_sel = pin_s2_r[1];
	assign lp_sel = pin_s2_r[2];
	assign ser_sel = pin_s2_r[3];
	assign ext_clk = ser_sel & pin_s2_r[4 + `AOPC_PIN_CLK_SRC]; // R7
	assign sync_pol = ser_sel & pin_s2_r[4 + `AOPC_PIN_SYNC_POL]; // R8
	assign clk_inv = ser_sel & pin_s2_r[4 + `AOPC_PIN_CLK_INV]; // R9
	assign read_mode = pin_s2_r[4 + `AOPC_PIN_READ_MODE];

	// ----------------------------------------------------------------
	// result encoding and conversion mode
	// ----------------------------------------------------------------
	assign coded = enc_sel ? result_i : {~result_i[15], result_i[14:0]}; // R1

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= AOPC_MODE_NORMAL;
		end else begin
			case ({fast_sel, lp_sel})
				2'b10: mode_r <= AOPC_MODE_FAST; // R2
				2'b01: mode_r <= AOPC_MODE_LOW_POWER; // R4
				2'b00: mode_r <= AOPC_MODE_NORMAL; // R13
				default: mode_r <= AOPC_MODE_UNSUPPORTED; // R13
			endcase
		end
	end

	// fast mode loses accuracy when conversions come too far apart
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_cnt_r <= 17'h00000;
			risk_r <= 1'b0;
		end else if (mode_r != AOPC_MODE_FAST) begin
			idle_cnt_r <= 17'h00000;
			risk_r <= 1'b0; // R3
		end else if (result_valid_i) begin
			idle_cnt_r <= 17'h00000;
			risk_r <= 1'b0;
		end else begin
			if (idle_cnt_r < IDLE_LIMIT) begin
				idle_cnt_r <= idle_cnt_r + 17'h00001;
			end
			risk_r <= (idle_cnt_r >= IDLE_LIMIT); // R2
		end
	end

	// ----------------------------------------------------------------
	// parallel port and pin roles
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			word_r <= `AOPC_WORD_RST;
		end else if (result_valid_i) begin
			word_r <= coded;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_r <= `AOPC_WORD_RST;
			oe_n_r <= 4'h0;
		end else if (ser_sel) begin
			data_r <= {12'h000, word_r[3:0]}; // R6
			oe_n_r <= 4'hF; // R5
		end else begin
			data_r <= word_r; // R5
			oe_n_r <= 4'h0; // R7 R8 R9
		end
	end

	// ----------------------------------------------------------------
	// handoff to the external clock shifter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ser.ack_tgl;
			ack_s2_r <= ack_s1_r;
		end
	end

	// a word arriving while the previous one is unclaimed is not offered
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_r <= `AOPC_WORD_RST;
			req_r <= 1'b0;
		end else if (ext_clk && result_valid_i && (req_r == ack_s2_r)) begin
			hold_r <= coded;
			req_r <= ~req_r;
		end
	end

	assign ser.hold_word = hold_r;
	assign ser.req_tgl = req_r;
	assign ser.cs_n = cs_n_i;
	assign ser.chain_in = data_i[7];
	// inversion moves the active edge to the falling one
	assign link_clk = sclk_ext_i ^ clk_inv; // R11

	aopc_ser_link u_link (
		.link_clk_i(link_clk),
		.rst_i(rst_i),
		.ser(ser.link)
	);

	// ----------------------------------------------------------------
	// internal clock serial master
	// ----------------------------------------------------------------
	assign mst_start = ser_sel && !ext_clk && (ms_r == AOPC_MS_IDLE) &&
		(read_mode ? conv_start_i : result_valid_i); // R12

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ms_r <= AOPC_MS_IDLE;
			ph_r <= 3'h0;
			bit_r <= 5'h00;
		end else begin
			case (ms_r)
				AOPC_MS_IDLE: begin
					if (mst_start) begin
						ms_r <= AOPC_MS_SYNC;
					end
				end
				AOPC_MS_SYNC: begin
					ms_r <= AOPC_MS_HIGH;
					ph_r <= 3'h0;
					bit_r <= 5'h00;
				end
				AOPC_MS_HIGH: begin
					if (ph_r == HIGH_LAST) begin
						ms_r <= AOPC_MS_LOW;
						ph_r <= 3'h0;
					end else begin
						ph_r <= ph_r + 3'h1;
					end
				end
				AOPC_MS_LOW: begin
					ph_r <= 3'h0;
					if (ph_r != LOW_LAST) begin
						ph_r <= ph_r + 3'h1;
					end else if (bit_r == `AOPC_WORD_BITS - 5'h01) begin
						ms_r <= AOPC_MS_END;
					end else begin
						ms_r <= AOPC_MS_HIGH;
						bit_r <= bit_r + 5'h01;
					end
				end
				default: begin
					ms_r <= AOPC_MS_IDLE;
				end
			endcase
		end
	end

	// during-conversion read sends the stored word, else the fresh one
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mshift_r <= `AOPC_WORD_RST;
			msdo_r <= 1'b0;
		end else if (mst_start) begin
			mshift_r <= read_mode ? {word_r[14:0], 1'b0} : {coded[14:0], 1'b0}; // R12
			msdo_r <= read_mode ? word_r[15] : coded[15]; // R10
		end else if (ms_r == AOPC_MS_HIGH && ph_r == MID_PH && bit_r != 5'h00) begin
			msdo_r <= mshift_r[15]; // R10
			mshift_r <= {mshift_r[14:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_r <= 1'b0;
			sclk_oe_n_r <= 1'b1;
			sync_r <= 1'b0;
		end else begin
			sclk_r <= (ms_r == AOPC_MS_HIGH) ^ clk_inv; // R9
			sclk_oe_n_r <= !(ser_sel && !ext_clk); // R7
			sync_r <= ((ms_r == AOPC_MS_SYNC) || (ms_r == AOPC_MS_HIGH) ||
				(ms_r == AOPC_MS_LOW)) ^ sync_pol; // R8
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign data_o = data_r;
	assign data_oe_n_o = oe_n_r;
	assign serial_result_out_o = ext_clk ? ser.sdo : msdo_r; // R11
	assign sclk_o = sclk_r;
	assign sclk_oe_n_o = sclk_oe_n_r;
	assign frame_sync_o = sync_r;
	assign conv_mode_o = mode_r;
	assign accuracy_risk_o = risk_r;
endmodule // aopc_top
